// ===== emb_sequencer.sv
// external memory bus sequencer: fetch, data read, data write, port timing
// assumes the user holds a request until req_taken pulses, and
// that all pin inputs are synchronous to mclk
`timescale 1ns/1ns
`include "emb_consts.svh"

module emb_sequencer
  import emb_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire emb_req_s     req,
  output logic              req_taken,
  output logic              busy,
  output logic              done,
  output logic [7:0]        rdata,
  input  wire logic [7:0]   shared_addr_data_port_in,
  output logic [7:0]        shared_addr_data_port_out,
  output logic              shared_addr_data_port_oe,
  output logic [7:0]        high_address_port,
  output emb_strobes_s      strobes,
  input  wire logic [7:0]   port_pins_in,
  input  wire logic [7:0]   port_wdata,
  output logic [7:0]        port_sample,
  output logic [7:0]        port_pins_out,
  output logic              state_five_phase_two,
  output logic              state_six_phase_two,
  input  wire logic         prog_rst_pin,
  input  wire logic         prog_ale_pin,
  input  wire logic         prog_fetch_pin,
  output logic              flash_mode
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [3:0] c, input int n);
    hit = (c == 4'(n));
  endfunction

  function automatic logic span(input logic [3:0] c, input int lo, input int hi);
    span = (c >= 4'(lo)) && (c < 4'(hi));
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  emb_state_e   state_r,   state_nxt;
  emb_op_e      op_r,      op_nxt;
  logic [3:0]   cnt_r,     cnt_nxt;
  logic [3:0]   mc_r,      mc_nxt;
  logic [1:0]   div_r,     div_nxt;
  logic [15:0]  addr_r,    addr_nxt;
  logic [7:0]   wdata_r,   wdata_nxt;
  logic         taken_r,   taken_nxt;
  logic         busy_r,    busy_nxt;
  logic         done_r,    done_nxt;
  logic [7:0]   rdata_r,   rdata_nxt;
  logic [7:0]   lo_out_r,  lo_out_nxt;
  logic         lo_oe_r,   lo_oe_nxt;
  logic [7:0]   hi_r,      hi_nxt;
  emb_strobes_s stb_r,     stb_nxt;
  logic [7:0]   psamp_r,   psamp_nxt;
  logic [7:0]   pout_r,    pout_nxt;
  logic         samp_r,    samp_nxt;
  logic         updt_r,    updt_nxt;
  logic         flash_r,   flash_nxt;

  logic         tick;
  logic [3:0]   c;
  logic [3:0]   len;

  assign tick = (div_r == 2'(`EMB_OSC_DIV - 1));
  assign c    = cnt_r + 4'h1;
  assign len  = (op_r == EMB_OP_FETCH) ? 4'(`EMB_FETCH_LEN) : 4'(`EMB_DATA_LEN);

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb
  begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    cnt_nxt    = cnt_r;
    mc_nxt     = mc_r;
    div_nxt    = tick ? 2'h0 : div_r + 2'h1;
    addr_nxt   = addr_r;
    wdata_nxt  = wdata_r;
    taken_nxt  = 1'b0;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    rdata_nxt  = rdata_r;
    lo_out_nxt = lo_out_r;
    lo_oe_nxt  = lo_oe_r;
    hi_nxt     = hi_r;
    stb_nxt    = stb_r;
    psamp_nxt  = psamp_r;
    pout_nxt   = pout_r;
    samp_nxt   = 1'b0;
    updt_nxt   = 1'b0;
    // flash reachable only with all three pins high
    flash_nxt  = prog_rst_pin & prog_ale_pin & prog_fetch_pin;
    stb_nxt.ctl_oe = ~flash_r;
    if (tick)
    begin
      mc_nxt = hit(mc_r, `EMB_MC_LEN - 1) ? 4'h0 : mc_r + 4'h1;
      if (hit(mc_r, `EMB_SAMPLE_PH))
      begin
        psamp_nxt = port_pins_in;
        samp_nxt  = 1'b1;
      end
      if (hit(mc_r, `EMB_UPDATE_PH))
      begin
        pout_nxt = port_wdata;
        updt_nxt = 1'b1;
      end
      case (state_r)
        EMB_ST_IDLE:
        begin
          if (req.valid && !flash_r)
          begin
            state_nxt   = EMB_ST_RUN;
            op_nxt      = req.op;
            addr_nxt    = req.addr;
            wdata_nxt   = req.wdata;
            cnt_nxt     = 4'h0;
            taken_nxt   = 1'b1;
            busy_nxt    = 1'b1;
            stb_nxt.ale = 1'b1;
            lo_out_nxt  = req.addr[7:0];
            lo_oe_nxt   = 1'b1;
            hi_nxt      = req.addr[15:8];
          end
        end
        EMB_ST_RUN:
        begin
          cnt_nxt     = c;
          hi_nxt      = addr_r[15:8];
          stb_nxt.ale = span(c, 0, `EMB_ALE_FALL);
          // address held one period past the latch fall
          lo_oe_nxt   = span(c, 0, `EMB_ADDR_REL);
          lo_out_nxt  = addr_r[7:0];
          if (op_r == EMB_OP_WRITE && span(c, `EMB_WDATA_ON, `EMB_WDATA_OFF))
          begin
            lo_oe_nxt  = 1'b1;
            lo_out_nxt = wdata_r;
          end
          // three-period fetch window
          stb_nxt.code_fetch_strobe_n =
            !(op_r == EMB_OP_FETCH && span(c, `EMB_FETCH_LOW, `EMB_FETCH_HIGH));
          // six-period strobe inside an eight-period window
          stb_nxt.rd_n = !(op_r == EMB_OP_READ && span(c, `EMB_STB_LOW, `EMB_STB_HIGH));
          stb_nxt.wr_n = !(op_r == EMB_OP_WRITE && span(c, `EMB_STB_LOW, `EMB_STB_HIGH));
          // captured on the edge that raises the strobe
          if ((op_r == EMB_OP_FETCH && hit(c, `EMB_FETCH_HIGH)) ||
              (op_r == EMB_OP_READ && hit(c, `EMB_STB_HIGH)))
          begin
            rdata_nxt = shared_addr_data_port_in;
          end
          // read cycle keeps three float periods after the strobe rise before it ends
          if (c == len)
          begin
            state_nxt = EMB_ST_IDLE;
            busy_nxt  = 1'b0;
            done_nxt  = 1'b1;
          end
        end
        default:
        begin
          state_nxt = EMB_ST_IDLE;
          busy_nxt  = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= EMB_ST_IDLE;
      op_r     <= EMB_OP_FETCH;
      cnt_r    <= 4'h0;
      mc_r     <= 4'h0;
      div_r    <= 2'h0;
      addr_r   <= 16'h0000;
      wdata_r  <= 8'h00;
      taken_r  <= 1'b0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      rdata_r  <= 8'h00;
      lo_out_r <= 8'h00;
      lo_oe_r  <= 1'b0;
      hi_r     <= 8'h00;
      stb_r    <= '{ale: 1'b0, code_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                    ctl_oe: 1'b1};
      psamp_r  <= 8'h00;
      pout_r   <= 8'hff;
      samp_r   <= 1'b0;
      updt_r   <= 1'b0;
      flash_r  <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      cnt_r    <= cnt_nxt;
      mc_r     <= mc_nxt;
      div_r    <= div_nxt;
      addr_r   <= addr_nxt;
      wdata_r  <= wdata_nxt;
      taken_r  <= taken_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      rdata_r  <= rdata_nxt;
      lo_out_r <= lo_out_nxt;
      lo_oe_r  <= lo_oe_nxt;
      hi_r     <= hi_nxt;
      stb_r    <= stb_nxt;
      psamp_r  <= psamp_nxt;
      pout_r   <= pout_nxt;
      samp_r   <= samp_nxt;
      updt_r   <= updt_nxt;
      flash_r  <= flash_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign req_taken                 = taken_r;
  assign busy                      = busy_r;
  assign done                      = done_r;
  assign rdata                     = rdata_r;
  assign shared_addr_data_port_out = lo_out_r;
  assign shared_addr_data_port_oe  = lo_oe_r;
  assign high_address_port         = hi_r;
  assign strobes                   = stb_r;
  assign port_sample               = psamp_r;
  assign port_pins_out             = pout_r;
  assign state_five_phase_two      = samp_r;
  assign state_six_phase_two       = updt_r;
  assign flash_mode                = flash_r;

endmodule

// ===== emb_consts.svh
// timing and phase constants of the external bus sequencer
// assumes a 50 MHz mclk; one oscillator period is an enable tick from a divider
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// ****************************************************************
// clock and oscillator period
// ****************************************************************
`define EMB_MCLK_NS      20
`define EMB_TCP_NS       60
`define EMB_OSC_DIV      (((`EMB_TCP_NS) + (`EMB_MCLK_NS) - 1) / (`EMB_MCLK_NS))

// ****************************************************************
// cycle positions, in oscillator periods from the cycle start
// ****************************************************************
`define EMB_ALE_FALL     2
`define EMB_ADDR_REL     3
`define EMB_FETCH_LOW    3
`define EMB_FETCH_HIGH   6
`define EMB_FETCH_LEN    6
`define EMB_STB_LOW      5
`define EMB_STB_HIGH     11
`define EMB_WDATA_ON     4
`define EMB_WDATA_OFF    12
`define EMB_DATA_LEN     14

// ****************************************************************
// machine cycle phases, one per oscillator period (0 .. 11)
// ****************************************************************
`define EMB_MC_LEN       12
`define EMB_SAMPLE_PH    9
`define EMB_UPDATE_PH    11

`endif

// ===== emb_pkg.sv
// types of the external bus sequencer
// assumes emb_consts.svh holds all numbers
package emb_pkg;

  typedef enum logic [1:0]
  {
    EMB_OP_FETCH = 2'b00,
    EMB_OP_READ  = 2'b01,
    EMB_OP_WRITE = 2'b10
  } emb_op_e;

  typedef enum logic [1:0]
  {
    EMB_ST_IDLE = 2'b00,
    EMB_ST_RUN  = 2'b01
  } emb_state_e;

  typedef struct packed
  {
    logic        valid;
    emb_op_e     op;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emb_req_s;

  typedef struct packed
  {
    logic        ale;
    logic        code_fetch_strobe_n;
    logic        rd_n;
    logic        wr_n;
    logic        ctl_oe;
  } emb_strobes_s;

endpackage

// ===== emb_seq_monitor.sv
// checker of the external bus sequencer pin timing
// assumes one oscillator period is three mclk and pins change on ticks
`timescale 1ns/1ns
module emb_seq_monitor
  import emb_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst_n,
  input wire logic         req_taken,
  input wire logic         busy,
  input wire logic [7:0]   rdata,
  input wire logic [7:0]   shared_addr_data_port_in,
  input wire logic         shared_addr_data_port_oe,
  input wire logic [7:0]   high_address_port,
  input wire emb_strobes_s strobes,
  input wire logic [7:0]   port_pins_in,
  input wire logic [7:0]   port_wdata,
  input wire logic [7:0]   port_sample,
  input wire logic [7:0]   port_pins_out,
  input wire logic         state_five_phase_two,
  input wire logic         state_six_phase_two,
  input wire logic         flash_mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // assertions
  // ****************************************************************
  addr_setup_a: assert property ($fell(strobes.ale) |-> $past(shared_addr_data_port_oe, 3))
    else $error("low address not driven before latch strobe fell");
  addr_hold_a: assert property ($fell(strobes.ale) |-> shared_addr_data_port_oe[*3])
    else $error("low address released too early");
  addr_steady_a: assert property (busy && $past(busy) |-> $stable(high_address_port))
    else $error("high address moved inside a cycle");
  byte_capture_a: assert property (($rose(strobes.code_fetch_strobe_n) || $rose(strobes.rd_n))
    |-> rdata == $past(shared_addr_data_port_in))
    else $error("byte not captured at strobe rise");
  fetch_window_a: assert property ($fell(strobes.code_fetch_strobe_n) |->
    (!strobes.code_fetch_strobe_n)[*8] ##1 !strobes.code_fetch_strobe_n ##1 strobes.code_fetch_strobe_n)
    else $error("fetch strobe width wrong");
  read_window_a: assert property ($fell(strobes.rd_n) |->
    (!strobes.rd_n)[*8] ##1 (!strobes.rd_n)[*8] ##1 (!strobes.rd_n)[*2] ##1 strobes.rd_n)
    else $error("read strobe width wrong");
  wdata_setup_a: assert property ($fell(strobes.wr_n) |-> $past(shared_addr_data_port_oe, 3))
    else $error("write data not ahead of write strobe");
  wdata_hold_a: assert property ($rose(strobes.wr_n) |-> shared_addr_data_port_oe[*3])
    else $error("write data dropped too early");
  phase_gap_a: assert property ($rose(state_five_phase_two) |-> ##6 state_six_phase_two)
    else $error("port update not two periods after sample");
  port_sample_a: assert property (state_five_phase_two |-> port_sample == $past(port_pins_in))
    else $error("port sample wrong");
  port_update_a: assert property (state_six_phase_two |-> port_pins_out == $past(port_wdata))
    else $error("port output wrong");
  flash_gate_a: assert property (req_taken |-> !$past(flash_mode))
    else $error("cycle taken in flash mode");
endmodule

bind emb_sequencer emb_seq_monitor u_mon (.mclk, .rst_n, .req_taken, .busy, .rdata,
  .shared_addr_data_port_in, .shared_addr_data_port_oe, .high_address_port, .strobes,
  .port_pins_in, .port_wdata, .port_sample, .port_pins_out, .state_five_phase_two,
  .state_six_phase_two, .flash_mode);

// ===== emb_mem_model.sv
// external memory with address latch, facing the sequencer pins
// assumes index = low xor high address; released port shows inverse of last level
`timescale 1ns/1ns
module emb_mem_model
  import emb_pkg::*;
(
  input  wire logic         mclk,
  input  wire emb_strobes_s strobes,
  input  wire logic [7:0]   port_out,
  input  wire logic         port_oe,
  input  wire logic [7:0]   high_addr,
  input  wire logic         slow,
  output logic [7:0]        port_in
);
  logic [7:0] mem_r [256];
  logic [7:0] idx_r;
  logic [7:0] last_r = 8'h00;
  logic       ale_q;
  logic       wr_q;
  logic       strobe_low;
  int         wait_r;
  initial for (int i = 0; i < 256; i++) mem_r[i] = 8'(i) ^ 8'h5A;
  assign strobe_low = !strobes.code_fetch_strobe_n || !strobes.rd_n;
  always @(posedge mclk)
  begin
    ale_q  <= strobes.ale;
    wr_q   <= strobes.wr_n;
    last_r <= port_in;
    wait_r <= strobe_low ? wait_r + 1 : 0;
    if (ale_q && !strobes.ale) idx_r <= port_out ^ high_addr;
    if (!wr_q && strobes.wr_n) mem_r[idx_r] <= port_out;
  end
  // slow answer after 5 mclk, inside both access limits; float at once on rise
  assign port_in = port_oe ? port_out : (strobe_low && wait_r >= (slow ? 5 : 0)) ?
    mem_r[idx_r] : ~last_r;
endmodule

// ===== test_external_memory_bus_sequencer.sv
// testbench of the external bus sequencer with a memory model
// assumes a 50 MHz mclk and the request hold handshake
`timescale 1ns/1ns
module test_external_memory_bus_sequencer
  import emb_pkg::*;
;
  logic         mclk = 0, rst_n = 0, slow = 0, req_taken, busy, done, flash_mode;
  logic         prog_rst_pin = 0, prog_ale_pin = 0, prog_fetch_pin = 0;
  logic         shared_addr_data_port_oe, state_five_phase_two, state_six_phase_two;
  logic [7:0]   rdata, shared_addr_data_port_in, shared_addr_data_port_out;
  logic [7:0]   high_address_port, port_sample, port_pins_out;
  logic [7:0]   port_pins_in = 8'h00, port_wdata = 8'h00;
  emb_req_s     req = '0;
  emb_strobes_s strobes;
  int           err_count = 0, checked = 0;
  // programmer pulse of 300 us while the sequencer stays off the bus
  localparam int PULSE_CYC = 15000;
  always #10 mclk = ~mclk;
  emb_sequencer u_dut (.mclk, .rst_n, .req, .req_taken, .busy, .done, .rdata,
    .shared_addr_data_port_in, .shared_addr_data_port_out, .shared_addr_data_port_oe,
    .high_address_port, .strobes, .port_pins_in, .port_wdata, .port_sample, .port_pins_out,
    .state_five_phase_two, .state_six_phase_two, .prog_rst_pin, .prog_ale_pin,
    .prog_fetch_pin, .flash_mode);
  emb_mem_model u_mem (.mclk, .strobes, .port_out(shared_addr_data_port_out),
    .port_oe(shared_addr_data_port_oe), .high_addr(high_address_port), .slow,
    .port_in(shared_addr_data_port_in));
  task chk(input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task do_req(input emb_op_e op, input logic [15:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    req <= '{1'b1, op, a, wd};
    @(posedge mclk);
    while (req_taken !== 1'b1 && n < 40) begin @(posedge mclk); n++; end
    req.valid <= 1'b0;
    chk(high_address_port, a[15:8]);
    chk({7'h0, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 60) begin @(posedge mclk); n++; end
    chk({7'h0, done}, 8'h01);
    chk({7'h0, busy}, 8'h00);
  endtask
  task t_fetch;
    do_req(EMB_OP_FETCH, 16'h12C3, 8'h00);
    chk(rdata, 8'h8B);
    slow <= 1'b1;
    do_req(EMB_OP_FETCH, 16'hFF3C, 8'h00);
    chk(rdata, 8'h99);
    slow <= 1'b0;
    $display("test fetch done");
  endtask
  task t_data;
    do_req(EMB_OP_WRITE, 16'h3455, 8'h9E);
    do_req(EMB_OP_READ, 16'h3455, 8'h00);
    chk(rdata, 8'h9E);
    slow <= 1'b1;
    do_req(EMB_OP_READ, 16'h0102, 8'h00);
    chk(rdata, 8'h59);
    slow <= 1'b0;
    $display("test data done");
  endtask
  task t_port;
    int n;
    port_pins_in <= 8'hC7;
    port_wdata <= 8'h3B;
    repeat (2)
    begin
      n = 0;
      @(posedge mclk);
      while (state_six_phase_two !== 1'b1 && n < 40) begin @(posedge mclk); n++; end
    end
    chk(port_sample, 8'hC7);
    chk(port_pins_out, 8'h3B);
    $display("test port done");
  endtask
  task t_flash;
    logic seen;
    seen = 1'b0;
    prog_rst_pin <= 1'b1;
    prog_ale_pin <= 1'b1;
    prog_fetch_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({7'h0, flash_mode}, 8'h01);
    chk({7'h0, strobes.ctl_oe}, 8'h00);
    req <= '{1'b1, EMB_OP_FETCH, 16'h0203, 8'h00};
    repeat (PULSE_CYC) begin @(posedge mclk); seen = seen | req_taken; end
    chk({7'h0, seen}, 8'h00);
    prog_ale_pin <= 1'b0;
    do_req(EMB_OP_FETCH, 16'h0203, 8'h00);
    chk(rdata, 8'h5B);
    chk({7'h0, strobes.ctl_oe}, 8'h01);
    $display("test flash done");
  endtask
  task close_out;
    $display("counts: %0d compared, %0d mismatched", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_fetch;
    t_data;
    t_port;
    t_flash;
    close_out;
  end
  initial
  begin
    #800000;
    err_count++;
    close_out;
  end
endmodule
